//--- design/plsc_pkg.sv
package plsc_pkg;

	// Register byte offsets in configuration space
	localparam logic [7:0] PLSC_LINK_STATE_REPORT_OFS = 8'hd0;
	localparam logic [7:0] PLSC_SLOT_FEATURE_CAPS_OFS = 8'hd4;

	// Link state report fields
	localparam int PLSC_SPEED_LSB = 16;
	localparam int PLSC_SPEED_MSB = 19;
	localparam int PLSC_WIDTH_LSB = 20;
	localparam int PLSC_WIDTH_MSB = 25;
	localparam int PLSC_TRAIN_ERR_BIT = 26;
	localparam int PLSC_TRAINING_BIT = 27;
	localparam int PLSC_SLOT_CLK_BIT = 28;
	localparam int PLSC_DL_ACTIVE_BIT = 29;

	// Slot feature caps fields
	localparam int PLSC_ATTN_BTN_BIT = 0;
	localparam int PLSC_PWR_CTRL_BIT = 1;
	localparam int PLSC_ATTN_IND_BIT = 3;
	localparam int PLSC_PWR_IND_BIT = 4;
	localparam int PLSC_HP_SURPRISE_BIT = 5;
	localparam int PLSC_HP_CAPABLE_BIT = 6;
	localparam int PLSC_SPL_VAL_LSB = 7;
	localparam int PLSC_SPL_VAL_MSB = 14;
	localparam int PLSC_SPL_SCL_LSB = 15;
	localparam int PLSC_SPL_SCL_MSB = 16;
	localparam int PLSC_SLOT_NUM_LSB = 19;
	localparam int PLSC_SLOT_NUM_MSB = 31;

	// Field codes and reset values
	localparam logic [3:0] PLSC_SPEED_2G5 = 4'h1;
	localparam logic [3:0] PLSC_SPEED_5G0 = 4'h2;
	localparam logic [3:0] PLSC_SPEED_RST = 4'h2;
	localparam logic [5:0] PLSC_WIDTH_X1 = 6'h01;
	localparam logic [5:0] PLSC_WIDTH_RST = 6'h01;
	localparam logic [7:0] PLSC_SPL_VAL_RST = 8'h00;
	localparam logic [1:0] PLSC_SPL_SCL_RST = 2'h0;
	localparam logic [12:0] PLSC_SLOT_NUM_RST = 13'h0000;
	localparam logic [31:0] PLSC_WORD_ZERO = 32'h0000_0000;

	// Byte lanes that cover the power limit value and scale fields
	localparam logic [3:0] PLSC_SPL_BYTE_MASK = 4'h7;

	// Values that the SMBus or EEPROM loader may replace
	typedef struct packed {
		logic [12:0] slot_num;
		logic [1:0] spl_scale;
		logic [7:0] spl_value;
		logic hp_capable;
		logic hp_surprise;
		logic pwr_ind;
		logic attn_ind;
		logic pwr_ctrl;
		logic attn_btn;
		logic slot_clk;
	} plsc_load_s;

	// Events from the link training and data link logic
	typedef struct packed {
		logic train_start;
		logic train_fail;
		logic train_done;
		logic [3:0] speed;
		logic [5:0] width;
		logic dl_active;
	} plsc_link_ev_s;

	// Configuration space access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} plsc_cfg_req_s;

	typedef enum logic [3:0] {
		PLSC_LT_IDLE = 4'b0001,
		PLSC_LT_TRAIN = 4'b0010,
		PLSC_LT_L0 = 4'b0100,
		PLSC_LT_FAIL = 4'b1000
	} plsc_lt_state_e;

endpackage

//--- design/plsc_regs.sv
// Contract
// - Link speed at 19:16, 0001b 2.5G, 0010b 5.0G, resets to 0010b.
// - Negotiated width at 25:20, 0001b means x1, resets to 0001b.
// - Training error bit 26 set on failure, cleared on reaching L0.
// - Training bit 27 high while training runs, cleared when done.
// - Slot clock bit 28 follows strap at reset, loader may override.
// - Bit 29 follows data link active one cycle late (registered), resets low.
// - Slot caps at D4h exist and apply on downstream ports only.
// - Attention button, power controller, attention indicator bits 0,1,3.
// - Power indicator present bit, resets zero, loadable.
// - Hot-plug surprise bit, resets zero, loadable.
// - Hot-plug capable bit, resets zero, loadable.
// - Power limit value resets 00h; a write sends power limit message. The code sends it only when byte lane 0, 1 or 2 is enabled.
// - Power limit scale resets 00b; a write sends power limit message. The code sends it only when byte lane 0, 1 or 2 is enabled.
// - Physical slot number resets to zero, loadable.
`timescale 1ns/1ps
module plsc_regs (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_downstream,
	input wire logic i_slot_clock_strap_pin,
	input wire plsc_pkg::plsc_cfg_req_s i_cfg,
	input wire logic i_load_valid,
	input wire plsc_pkg::plsc_load_s i_load,
	input wire plsc_pkg::plsc_link_ev_s i_link,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	output logic o_spl_msg_req,
	output logic [7:0] o_spl_value,
	output logic [1:0] o_spl_scale
);
	import plsc_pkg::*;

	logic rst_meta_r;
	logic rst_n_r;
	logic strap_done_r;
	logic slot_clk_r;
	logic dl_active_r;
	logic training;
	logic train_err;
	logic [3:0] speed;
	logic [5:0] width;
	logic attn_btn_r;
	logic pwr_ctrl_r;
	logic attn_ind_r;
	logic pwr_ind_r;
	logic hp_surprise_r;
	logic hp_capable_r;
	logic [12:0] slot_num_r;
	logic [7:0] spl_value_nxt;
	logic [1:0] spl_scale_nxt;
	logic spl_wr;
	logic [31:0] link_word;
	logic [31:0] caps_word;
	logic [31:0] wmask;
	logic [31:0] wval;

	// Reset release through two flops
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	plsc_train_track u_train (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n_r),
		.i_ev(i_link),
		.o_training(training),
		.o_train_err(train_err),
		.o_speed(speed),
		.o_width(width)
	);

	// Strap is sampled in the first cycle after release, not under reset
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strap_done_r <= 1'b0;
			slot_clk_r <= 1'b0;
		end else if (i_load_valid) begin
			strap_done_r <= 1'b1;
			slot_clk_r <= i_load.slot_clk;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			slot_clk_r <= i_slot_clock_strap_pin;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dl_active_r <= 1'b0;
		end else begin
			dl_active_r <= i_link.dl_active;
		end
	end

	// Loader-only capability bits; software has no write path
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			attn_btn_r <= 1'b0;
			pwr_ctrl_r <= 1'b0;
			attn_ind_r <= 1'b0;
			pwr_ind_r <= 1'b0;
			hp_surprise_r <= 1'b0;
			hp_capable_r <= 1'b0;
			slot_num_r <= PLSC_SLOT_NUM_RST;
		end else if (i_load_valid) begin
			attn_btn_r <= i_load.attn_btn;
			pwr_ctrl_r <= i_load.pwr_ctrl;
			attn_ind_r <= i_load.attn_ind;
			pwr_ind_r <= i_load.pwr_ind;
			hp_surprise_r <= i_load.hp_surprise;
			hp_capable_r <= i_load.hp_capable;
			slot_num_r <= i_load.slot_num;
		end
	end

	// Byte-enable expansion, one lane per generate step
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign wmask[8*g +: 8] = {8{i_cfg.be[g]}};
	end

	assign wval = i_cfg.wdata;

	// Upstream ports ignore writes to the slot caps word
	assign spl_wr = i_cfg.wr && i_downstream
		&& (i_cfg.addr == PLSC_SLOT_FEATURE_CAPS_OFS)
		&& ((i_cfg.be & PLSC_SPL_BYTE_MASK) != 4'h0);

	always_comb begin
		spl_value_nxt = o_spl_value;
		spl_scale_nxt = o_spl_scale;
		for (int b = 0; b < 8; b++) begin
			if (wmask[PLSC_SPL_VAL_LSB + b]) begin
				spl_value_nxt[b] = wval[PLSC_SPL_VAL_LSB + b];
			end
		end
		for (int b = 0; b < 2; b++) begin
			if (wmask[PLSC_SPL_SCL_LSB + b]) begin
				spl_scale_nxt[b] = wval[PLSC_SPL_SCL_LSB + b];
			end
		end
	end

	// Software write outranks a loader update in the same cycle
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_spl_value <= PLSC_SPL_VAL_RST;
			o_spl_scale <= PLSC_SPL_SCL_RST;
		end else if (spl_wr) begin
			o_spl_value <= spl_value_nxt;
			o_spl_scale <= spl_scale_nxt;
		end else if (i_load_valid) begin
			o_spl_value <= i_load.spl_value;
			o_spl_scale <= i_load.spl_scale;
		end
	end

	// Message request pulses once per qualifying write
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_spl_msg_req <= 1'b0;
		end else begin
			o_spl_msg_req <= spl_wr;
		end
	end

	always_comb begin
		link_word = PLSC_WORD_ZERO;
		link_word[PLSC_SPEED_MSB:PLSC_SPEED_LSB] = speed;
		link_word[PLSC_WIDTH_MSB:PLSC_WIDTH_LSB] = width;
		link_word[PLSC_TRAIN_ERR_BIT] = train_err;
		link_word[PLSC_TRAINING_BIT] = training;
		link_word[PLSC_SLOT_CLK_BIT] = slot_clk_r;
		link_word[PLSC_DL_ACTIVE_BIT] = dl_active_r;
	end

	always_comb begin
		caps_word = PLSC_WORD_ZERO;
		caps_word[PLSC_ATTN_BTN_BIT] = attn_btn_r;
		caps_word[PLSC_PWR_CTRL_BIT] = pwr_ctrl_r;
		caps_word[PLSC_ATTN_IND_BIT] = attn_ind_r;
		caps_word[PLSC_PWR_IND_BIT] = pwr_ind_r;
		caps_word[PLSC_HP_SURPRISE_BIT] = hp_surprise_r;
		caps_word[PLSC_HP_CAPABLE_BIT] = hp_capable_r;
		caps_word[PLSC_SPL_VAL_MSB:PLSC_SPL_VAL_LSB] = o_spl_value;
		caps_word[PLSC_SPL_SCL_MSB:PLSC_SPL_SCL_LSB] = o_spl_scale;
		caps_word[PLSC_SLOT_NUM_MSB:PLSC_SLOT_NUM_LSB] = slot_num_r;
	end

	// Read data registered one cycle after the strobe; others read zero
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_cfg_rdata <= PLSC_WORD_ZERO;
			o_cfg_rvalid <= 1'b0;
		end else begin
			o_cfg_rvalid <= i_cfg.rd;
			if (!i_cfg.rd) begin
				o_cfg_rdata <= PLSC_WORD_ZERO;
			end else if (i_cfg.addr == PLSC_LINK_STATE_REPORT_OFS) begin
				o_cfg_rdata <= link_word;
			end else if (i_cfg.addr == PLSC_SLOT_FEATURE_CAPS_OFS
				&& i_downstream) begin
				o_cfg_rdata <= caps_word;
			end else begin
				o_cfg_rdata <= PLSC_WORD_ZERO;
			end
		end
	end

endmodule // plsc_regs

//--- design/plsc_train_track.sv
`timescale 1ns/1ps
module plsc_train_track (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire plsc_pkg::plsc_link_ev_s i_ev,
	output logic o_training,
	output logic o_train_err,
	output logic [3:0] o_speed,
	output logic [5:0] o_width
);
	import plsc_pkg::*;

	plsc_lt_state_e state_r;
	plsc_lt_state_e state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PLSC_LT_IDLE, PLSC_LT_L0, PLSC_LT_FAIL: begin
				if (i_ev.train_start) begin
					state_nxt = PLSC_LT_TRAIN;
				end
			end
			PLSC_LT_TRAIN: begin
				// Failure outranks success if both are flagged together
				if (i_ev.train_fail) begin
					state_nxt = PLSC_LT_FAIL;
				end else if (i_ev.train_done) begin
					state_nxt = PLSC_LT_L0;
				end
			end
			default: begin
				state_nxt = PLSC_LT_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= PLSC_LT_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// High only while training runs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_training <= 1'b0;
		end else begin
			o_training <= (state_nxt == PLSC_LT_TRAIN);
		end
	end

	// A fail seen with a success still sets the flag
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_train_err <= 1'b0;
		end else if (i_ev.train_fail) begin
			o_train_err <= 1'b1;
		end else if (state_r == PLSC_LT_TRAIN && i_ev.train_done) begin
			o_train_err <= 1'b0;
		end
	end

	// Speed and width are latched only when the link reaches L0
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_speed <= PLSC_SPEED_RST;
			o_width <= PLSC_WIDTH_RST;
		end else if (state_nxt == PLSC_LT_L0 && state_r == PLSC_LT_TRAIN) begin
			o_speed <= i_ev.speed;
			o_width <= i_ev.width;
		end
	end

endmodule // plsc_train_track

//--- test/plsc_link_model.sv
`timescale 1ns/1ps
module plsc_link_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_go,
	input wire logic i_pass,
	input wire logic i_slow,
	input wire logic [3:0] i_speed,
	output plsc_pkg::plsc_link_ev_s o_ev
);
	import plsc_pkg::*;
	logic [3:0] cnt_r;
	logic busy_r;
	logic start_r;
	logic done_r;
	logic fail_r;
	logic dl_r;
	// A fundamental reset takes the link down, so the active level drops
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			start_r <= 1'b0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			dl_r <= 1'b0;
		end else begin
			start_r <= i_go;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			if (i_go) begin
				busy_r <= 1'b1;
				cnt_r <= i_slow ? 4'hc : 4'h3;
				dl_r <= 1'b0;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					busy_r <= 1'b0;
					done_r <= i_pass;
					fail_r <= !i_pass;
					dl_r <= i_pass;
				end
			end
		end
	end
	// Speed and width are only valid with done; garbage otherwise
	assign o_ev = {start_r, fail_r, done_r, done_r ? i_speed : ~i_speed,
		done_r ? 6'h01 : 6'h3e, dl_r};
endmodule // plsc_link_model

//--- test/plsc_regs_checker.sv
`timescale 1ns/1ps
module plsc_regs_checker (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_downstream,
	input wire logic i_slot_clock_strap_pin,
	input wire plsc_pkg::plsc_cfg_req_s i_cfg,
	input wire logic i_load_valid,
	input wire plsc_pkg::plsc_load_s i_load,
	input wire plsc_pkg::plsc_link_ev_s i_link,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_rvalid,
	input wire logic o_spl_msg_req,
	input wire logic [7:0] o_spl_value,
	input wire logic [1:0] o_spl_scale
);
	import plsc_pkg::*;
	logic wr_caps;
	logic rd_link;
	logic rd_caps;
	assign rd_caps = i_cfg.rd && i_cfg.addr == PLSC_SLOT_FEATURE_CAPS_OFS;
	assign rd_link = i_cfg.rd && i_cfg.addr == PLSC_LINK_STATE_REPORT_OFS;
	assign wr_caps = i_cfg.wr && i_cfg.addr == PLSC_SLOT_FEATURE_CAPS_OFS
		&& i_downstream && |i_cfg.be[2:0];
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	rd_answer_a: assert property (i_cfg.rd |=> o_cfg_rvalid)
		else $error("read not answered");
	idle_zero_a: assert property (!i_cfg.rd |=> !o_cfg_rvalid
		&& o_cfg_rdata == 32'h0) else $error("read data without read");
	rsvd_zero_a: assert property (rd_link |=> o_cfg_rdata[31:30] == 2'h0
		&& o_cfg_rdata[15:0] == 16'h0) else $error("reserved bits set");
	speed_code_a: assert property (rd_link |=> o_cfg_rdata[19:16]
		inside {4'h1, 4'h2}) else $error("bad speed code");
	width_code_a: assert property (rd_link |=> o_cfg_rdata[25:20]
		== 6'h01) else $error("bad width code");
	dl_follow_a: assert property ($past(rd_link) && o_cfg_rvalid
		&& $past(i_link.dl_active) == $past(i_link.dl_active, 2)
		|-> o_cfg_rdata[29] == $past(i_link.dl_active))
		else $error("link active bit wrong");
	caps_hidden_a: assert property (rd_caps && !i_downstream
		|=> o_cfg_rdata == 32'h0) else $error("caps seen upstream");
	msg_write_a: assert property (wr_caps |=> o_spl_msg_req)
		else $error("no power limit message");
	msg_only_a: assert property (!wr_caps |=> !o_spl_msg_req)
		else $error("stray power limit message");
	spl_load_a: assert property (wr_caps && i_cfg.be[2:0] == 3'h7
		|=> o_spl_value == $past(i_cfg.wdata[14:7])
		&& o_spl_scale == $past(i_cfg.wdata[16:15]))
		else $error("power limit not written");
	spl_hold_a: assert property (!wr_caps && !i_load_valid
		|=> $stable(o_spl_value) && $stable(o_spl_scale))
		else $error("power limit changed");
	cover property (rd_link);
	cover property (wr_caps);
	cover property (i_load_valid);
endmodule // plsc_regs_checker

//--- test/plsc_regs_tb.sv
`timescale 1ns/1ps
module plsc_regs_tb;
	import plsc_pkg::*;
	logic i_ref_clk;
	logic i_reset_n;
	logic i_downstream;
	logic i_slot_clock_strap_pin;
	plsc_cfg_req_s i_cfg;
	logic i_load_valid;
	plsc_load_s i_load;
	plsc_link_ev_s i_link;
	logic [31:0] o_cfg_rdata;
	logic o_cfg_rvalid;
	logic o_spl_msg_req;
	logic [7:0] o_spl_value;
	logic [1:0] o_spl_scale;
	logic go;
	logic pass;
	logic slow;
	logic msg;
	logic [3:0] spd;
	logic [31:0] rd_v;
	int n_mismatch;
	int checks;
	int cyc;
	plsc_regs plsc_regs_inst (.i_ref_clk, .i_reset_n, .i_downstream,
		.i_slot_clock_strap_pin, .i_cfg, .i_load_valid, .i_load, .i_link,
		.o_cfg_rdata, .o_cfg_rvalid, .o_spl_msg_req, .o_spl_value,
		.o_spl_scale);
	plsc_link_model plsc_link_model_inst (.i_ref_clk,
		.i_rst_n(i_reset_n), .i_go(go),
		.i_pass(pass), .i_slow(slow), .i_speed(spd), .o_ev(i_link));
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// Strobes drop for a cycle between requests, so no double assignment
	task automatic cfg_rd(input logic [7:0] a);
		i_cfg.rd = 1'b1;
		i_cfg.addr = a;
		tick(1);
		rd_v = o_cfg_rvalid ? o_cfg_rdata : 32'hdead_beef;
		i_cfg.rd = 1'b0;
		tick(1);
	endtask
	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		i_cfg.wr = 1'b1;
		i_cfg.addr = a;
		i_cfg.be = b;
		i_cfg.wdata = d;
		tick(1);
		msg = o_spl_msg_req;
		i_cfg.wr = 1'b0;
		tick(1);
	endtask
	task automatic do_reset(input logic ds, input logic strap);
		i_reset_n = 1'b0;
		i_downstream = ds;
		i_slot_clock_strap_pin = strap;
		tick(5);
		i_reset_n = 1'b1;
		tick(3);
	endtask
	task automatic t_reset(input logic [31:0] exp);
		cfg_rd(PLSC_LINK_STATE_REPORT_OFS);
		check(rd_v, exp);
		cfg_rd(PLSC_SLOT_FEATURE_CAPS_OFS);
		check(rd_v, 32'h0);
		check({o_spl_scale, o_spl_value}, 32'h0);
	endtask
	task automatic t_train(input logic p, input logic s,
		input logic [3:0] sp, input logic [31:0] exp);
		pass = p;
		slow = s;
		spd = sp;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(1);
		cfg_rd(PLSC_LINK_STATE_REPORT_OFS);
		check(rd_v[27], 1'b1);
		tick(16);
		cfg_rd(PLSC_LINK_STATE_REPORT_OFS);
		check(rd_v, exp);
	endtask
	task automatic t_caps();
		cfg_wr(PLSC_SLOT_FEATURE_CAPS_OFS, 4'hf, 32'hffff_ffff);
		check(msg, 1'b1);
		check({o_spl_scale, o_spl_value}, 32'h3ff);
		cfg_rd(PLSC_SLOT_FEATURE_CAPS_OFS);
		check(rd_v, 32'h0001_ff80);
		cfg_wr(PLSC_SLOT_FEATURE_CAPS_OFS, 4'h8, 32'h0);
		check(msg, 1'b0);
		cfg_wr(PLSC_SLOT_FEATURE_CAPS_OFS, 4'h1, 32'h0);
		check(msg, 1'b1);
		cfg_rd(PLSC_SLOT_FEATURE_CAPS_OFS);
		check(rd_v, 32'h0001_ff00);
		cfg_wr(PLSC_LINK_STATE_REPORT_OFS, 4'hf, 32'hffff_ffff);
		check(msg, 1'b0);
		cfg_rd(PLSC_LINK_STATE_REPORT_OFS);
		check(rd_v, 32'h3012_0000);
		cfg_rd(8'hd8);
		check(rd_v, 32'h0);
	endtask
	task automatic t_load();
		i_load = {13'h1fff, 2'h1, 8'h5a, 7'h7e};
		i_load_valid = 1'b1;
		tick(1);
		i_load_valid = 1'b0;
		check(o_spl_msg_req, 1'b0);
		tick(1);
		cfg_rd(PLSC_SLOT_FEATURE_CAPS_OFS);
		check(rd_v, 32'hfff8_ad7b);
		cfg_rd(PLSC_LINK_STATE_REPORT_OFS);
		check(rd_v, 32'h2012_0000);
	endtask
	task automatic t_upstream();
		do_reset(1'b0, 1'b0);
		t_reset(32'h0012_0000);
		cfg_wr(PLSC_SLOT_FEATURE_CAPS_OFS, 4'hf, 32'hffff_ffff);
		check(msg, 1'b0);
		check({o_spl_scale, o_spl_value}, 32'h0);
	endtask
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// Ceiling well above the roughly 114 cycles the run needs
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		i_cfg = '0;
		i_load = '0;
		i_load_valid = 1'b0;
		go = 1'b0;
		pass = 1'b0;
		slow = 1'b0;
		spd = 4'h1;
		do_reset(1'b1, 1'b1);
		t_reset(32'h1012_0000);
		t_train(1'b1, 1'b0, PLSC_SPEED_2G5, 32'h3011_0000);
		t_train(1'b0, 1'b1, PLSC_SPEED_5G0, 32'h1411_0000);
		t_train(1'b1, 1'b0, PLSC_SPEED_5G0, 32'h3012_0000);
		t_caps();
		t_load();
		t_upstream();
		summarize();
	end
endmodule // plsc_regs_tb
bind plsc_regs plsc_regs_checker plsc_regs_checker_inst (.i_ref_clk,
	.i_reset_n, .i_downstream, .i_slot_clock_strap_pin, .i_cfg,
	.i_load_valid, .i_load, .i_link, .o_cfg_rdata, .o_cfg_rvalid,
	.o_spl_msg_req, .o_spl_value, .o_spl_scale);
